// file: pkg/gain_switch_pkg.sv
package gain_switch_pkg;

  // ----------------------------------------------------------------
  // gain channels
  // ----------------------------------------------------------------
  localparam int          NUM_GAINS  = 7;
  localparam int          GW         = 16;
  localparam logic [2:0]  G_SPEED    = 3'h0;
  localparam logic [2:0]  G_INTEG    = 3'h1;
  localparam logic [2:0]  G_POS      = 3'h2;
  localparam logic [2:0]  G_FORCE    = 3'h3;
  localparam logic [2:0]  G_MODEL    = 3'h4;
  localparam logic [2:0]  G_MODEL_CP = 3'h5;
  localparam logic [2:0]  G_FRICTION = 3'h6;

  // packed high index first: friction, comp, model, force, pos, integ, speed
  localparam logic [NUM_GAINS-1:0][GW-1:0] GAIN_MIN = {
    16'h000A, 16'h01F4, 16'h000A, 16'h0000, 16'h000A, 16'h000F, 16'h000A};
  localparam logic [NUM_GAINS-1:0][GW-1:0] GAIN_MAX = {
    16'h03E8, 16'h07D0, 16'h4E20, 16'hFFFF, 16'h4E20, 16'hC800, 16'h4E20};
  localparam logic [NUM_GAINS-1:0][GW-1:0] GAIN_RST = {
    16'h0064, 16'h03E8, 16'h01F4, 16'h0064, 16'h0190, 16'h07D0, 16'h0190};

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CONFIG  = 8'h00;
  localparam logic [7:0]  ADDR_WAIT_1  = 8'h04;
  localparam logic [7:0]  ADDR_WAIT_2  = 8'h08;
  localparam logic [7:0]  ADDR_SWT_1   = 8'h0C;
  localparam logic [7:0]  ADDR_SWT_2   = 8'h10;
  localparam logic [7:0]  ADDR_STATUS  = 8'h14;
  localparam logic [2:0]  PAGE_SET_1   = 3'h2;   // 0x40 + 4*channel
  localparam logic [2:0]  PAGE_SET_2   = 3'h3;   // 0x60 + 4*channel
  localparam logic [15:0] CONFIG_RST   = 16'h0000;
  localparam logic [15:0] TIME_RST     = 16'h0000;

  // ----------------------------------------------------------------
  // config fields
  // ----------------------------------------------------------------
  localparam int          MODE_LSB     = 0;
  localparam int          COND_LSB     = 4;
  localparam logic [3:0]  MODE_AUTO    = 4'h2;
  localparam logic [3:0]  MODE_RESVD   = 4'h1;
  localparam logic [3:0]  COND_DONE_ON   = 4'h0;
  localparam logic [3:0]  COND_DONE_OFF  = 4'h1;
  localparam logic [3:0]  COND_NEAR_ON   = 4'h2;
  localparam logic [3:0]  COND_NEAR_OFF  = 4'h3;
  localparam logic [3:0]  COND_REF_IDLE  = 4'h4;
  localparam logic [3:0]  COND_REF_INPUT = 4'h5;

  // status bits
  localparam int          ST_ACTIVE    = 0;
  localparam int          ST_RAMPING   = 1;
  localparam int          ST_MODEL     = 2;
  localparam int          ST_COND_A    = 3;
  localparam int          ST_WAITING   = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          MS_STEP_NS    = 1000000;
  localparam int          MS_CYCLES_DEF = MS_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {IDLE_S, WAIT_S, RAMP_S} sw_state_t;

endpackage : gain_switch_pkg

// file: core/gain_switch.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1: manual mode: select bit 0 set 1, 1 set 2
// R2: auto switching only in position control, mode 2
// R3: condition A waits time 1 or 2, then switches
// R4: linear ramp over switching time 1 or 2
// R5: second digit picks condition A source 0..5
// R6: outside position control hold fixed set per selection
// R7: auto switching regardless of speed loop structure
// R8: speed gains limited to 10..20000
// R9: integral time limited to 15..51200
// R10: force filter time accepts 0..65535
// R11: model gains switch manually, idle and stopped
// R12: host never programs reserved mode 1
// R13: wait and ramp timed in 1 ms steps
// R14: condition revert during wait abandons switch
// R15: written values used on next control cycle
module gain_switch
  import gain_switch_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                        CLOCK,
  input  wire logic                        RST,
  // apb slave
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [7:0]                  PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  // drive state
  input  wire logic                        GAIN_SEL,
  input  wire logic                        POSITION_CONTROL,
  input  wire logic                        POSITIONING_DONE_FLAG,
  input  wire logic                        NEAR_POSITION_FLAG,
  input  wire logic                        REF_FILTER_IDLE,
  input  wire logic                        REF_INPUT_PRESENT,
  input  wire logic                        CMD_BUSY,
  input  wire logic                        MOTOR_STOPPED,
  // effective gains
  output logic [NUM_GAINS-1:0][GW-1:0]     EFF_GAIN,
  output logic                             ACTIVE_SET,
  output logic                             RAMPING
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [NUM_GAINS-1:0][GW-1:0] set1_r;
  logic [NUM_GAINS-1:0][GW-1:0] set2_r;
  logic [15:0]                  config_r;
  logic [15:0]                  wait1_r;
  logic [15:0]                  wait2_r;
  logic [15:0]                  swt1_r;
  logic [15:0]                  swt2_r;
  logic [31:0]                  ms_cnt_r;
  logic                         ms_tick;
  sw_state_t                    state_r;
  logic                         active_r;
  logic                         target_r;
  logic                         model_sel_r;
  logic [15:0]                  wait_cnt_r;
  logic [15:0]                  ramp_cnt_r;
  logic                         wr_en;
  logic                         setup;
  logic [2:0]                   chan;
  logic                         chan_ok;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign setup   = PSEL && !PENABLE;
  assign chan    = PADDR[4:2];
  assign chan_ok = (chan < 3'(NUM_GAINS)) && (PADDR[1:0] == 2'h0);
  assign PREADY  = 1'b1;
  function automatic logic [GW-1:0] clamp(input logic [2:0] idx, input logic [GW-1:0] v);
    logic [GW-1:0] r;
    r = v;
    if (v < GAIN_MIN[idx]) begin
      r = GAIN_MIN[idx];
    end else if (v > GAIN_MAX[idx]) begin
      r = GAIN_MAX[idx];
    end
    return r;
  endfunction : clamp

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // out-of-range writes are clamped rather than refused, so a set is always usable
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      set1_r <= GAIN_RST;
      set2_r <= GAIN_RST;
    end else if (wr_en && chan_ok) begin
      if (PADDR[7:5] == PAGE_SET_1) begin
        set1_r[chan] <= clamp(chan, PWDATA[GW-1:0]); // R8 R9 R10 R15
      end else if (PADDR[7:5] == PAGE_SET_2) begin
        set2_r[chan] <= clamp(chan, PWDATA[GW-1:0]); // R8 R9 R10 R15
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      config_r <= CONFIG_RST;
      wait1_r  <= TIME_RST;
      wait2_r  <= TIME_RST;
      swt1_r   <= TIME_RST;
      swt2_r   <= TIME_RST;
    end else if (wr_en) begin
      case (PADDR)
        ADDR_CONFIG: config_r <= PWDATA[15:0];
        ADDR_WAIT_1: wait1_r  <= PWDATA[15:0]; // R13
        ADDR_WAIT_2: wait2_r  <= PWDATA[15:0];
        ADDR_SWT_1:  swt1_r   <= PWDATA[15:0];
        ADDR_SWT_2:  swt2_r   <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic        cond_a;
  logic [31:0] status;
  logic        mapped;
  logic [31:0] rd_val;
  assign status = {27'h0, (state_r == WAIT_S), cond_a, model_sel_r,
                   (state_r == RAMP_S), active_r};
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0;
    case (PADDR)
      ADDR_CONFIG: rd_val = {16'h0, config_r};
      ADDR_WAIT_1: rd_val = {16'h0, wait1_r};
      ADDR_WAIT_2: rd_val = {16'h0, wait2_r};
      ADDR_SWT_1:  rd_val = {16'h0, swt1_r};
      ADDR_SWT_2:  rd_val = {16'h0, swt2_r};
      ADDR_STATUS: rd_val = status;
      default: begin
        if (chan_ok && PADDR[7:5] == PAGE_SET_1) begin
          rd_val = {16'h0, set1_r[chan]};
        end else if (chan_ok && PADDR[7:5] == PAGE_SET_2) begin
          rd_val = {16'h0, set2_r[chan]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // read data and error are captured in setup so both are flops during access
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= PWRITE ? 32'h0 : rd_val;
      PSLVERR <= !mapped || (PWRITE && PADDR == ADDR_STATUS);
    end
  end

  // ----------------------------------------------------------------
  // millisecond time base
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST || ms_tick) begin
      ms_cnt_r <= 32'h0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 32'h1;
    end
  end
  assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1)); // R13

  // ----------------------------------------------------------------
  // condition A and mode
  // ----------------------------------------------------------------
  logic [3:0] mode;
  logic [3:0] csel;
  logic       auto_mode;
  logic       auto_run;
  logic       fixed_set;
  logic       desired;
  logic       cur_wait_done;
  logic       cur_ramp_done;

  assign mode = config_r[MODE_LSB +: 4];
  assign csel = config_r[COND_LSB +: 4];
  // reserved mode 1 and unknown digits fall back to manual
  assign auto_mode = (mode == MODE_AUTO); // R2 R12
  // no dependence on speed loop structure: PI and I-P both switch
  assign auto_run  = auto_mode && POSITION_CONTROL; // R2 R7
  always_comb begin
    case (csel)
      COND_DONE_ON:   cond_a = POSITIONING_DONE_FLAG; // R5
      COND_DONE_OFF:  cond_a = !POSITIONING_DONE_FLAG;
      COND_NEAR_ON:   cond_a = NEAR_POSITION_FLAG;
      COND_NEAR_OFF:  cond_a = !NEAR_POSITION_FLAG;
      COND_REF_IDLE:  cond_a = REF_FILTER_IDLE && !REF_INPUT_PRESENT;
      COND_REF_INPUT: cond_a = REF_INPUT_PRESENT;
      default:        cond_a = POSITIONING_DONE_FLAG;
    endcase
  end
  assign fixed_set = csel[0]; // R6
  assign desired   = cond_a;
  assign cur_wait_done = (wait_cnt_r >= (target_r ? wait1_r : wait2_r)); // R3
  assign cur_ramp_done = (ramp_cnt_r >= (target_r ? swt1_r : swt2_r)); // R4

  // ----------------------------------------------------------------
  // switching sequencer
  // ----------------------------------------------------------------
  // a ramp already started runs to its end even if the condition flips
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_r    <= IDLE_S;
      active_r   <= 1'b0;
      target_r   <= 1'b0;
      wait_cnt_r <= 16'h0;
      ramp_cnt_r <= 16'h0;
    end else if (!auto_mode) begin
      state_r  <= IDLE_S;
      active_r <= GAIN_SEL; // R1
      target_r <= GAIN_SEL;
    end else if (!POSITION_CONTROL) begin
      state_r  <= IDLE_S;
      active_r <= fixed_set; // R6
      target_r <= fixed_set;
    end else begin
      case (state_r)
        IDLE_S: begin
          if (desired != active_r) begin
            state_r    <= WAIT_S; // R3
            target_r   <= desired;
            wait_cnt_r <= 16'h0;
          end
        end
        WAIT_S: begin
          if (desired == active_r) begin
            state_r <= IDLE_S; // R14
          end else if (cur_wait_done) begin
            state_r    <= RAMP_S;
            ramp_cnt_r <= 16'h0;
          end else if (ms_tick) begin
            wait_cnt_r <= wait_cnt_r + 16'h1; // R13
          end
        end
        RAMP_S: begin
          if (cur_ramp_done) begin
            state_r  <= IDLE_S;
            active_r <= target_r; // R4
          end else if (ms_tick) begin
            ramp_cnt_r <= ramp_cnt_r + 16'h1;
          end
        end
        default: state_r <= IDLE_S;
      endcase
    end
  end

  // model gains only follow the manual select while idle and stopped
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      model_sel_r <= 1'b0;
    end else if (!auto_mode && !CMD_BUSY && MOTOR_STOPPED) begin
      model_sel_r <= GAIN_SEL; // R11
    end
  end

  // ----------------------------------------------------------------
  // effective gains
  // ----------------------------------------------------------------
  logic [15:0] ramp_len;
  assign ramp_len = target_r ? swt1_r : swt2_r;

  genvar g;
  generate
    for (g = 0; g < NUM_GAINS; g++) begin : gen_gain
      logic [GW-1:0]      from_v;
      logic [GW-1:0]      to_v;
      logic signed [16:0] diff;
      logic signed [33:0] prod;
      logic signed [33:0] step;
      logic [GW-1:0]      eff_nxt;
      logic               is_model;
      assign is_model = (g == G_MODEL) || (g == G_MODEL_CP);
      assign from_v   = active_r ? set2_r[g] : set1_r[g];
      assign to_v     = target_r ? set2_r[g] : set1_r[g];
      assign diff     = $signed({1'b0, to_v}) - $signed({1'b0, from_v});
      assign prod     = diff * $signed({1'b0, ramp_cnt_r});
      assign step     = (ramp_len == 16'h0) ? 34'sh0 : prod / $signed({18'h0, ramp_len});
      always_comb begin
        if (is_model) begin
          eff_nxt = model_sel_r ? set2_r[g] : set1_r[g]; // R11
        end else if (state_r == RAMP_S) begin
          eff_nxt = GW'($signed({1'b0, from_v}) + step); // R4
        end else begin
          eff_nxt = from_v; // R15
        end
      end

      always_ff @(posedge CLOCK) begin
        if (RST) begin
          EFF_GAIN[g] <= GAIN_RST[g];
        end else begin
          EFF_GAIN[g] <= eff_nxt;
        end
      end
    end
  endgenerate
  assign ACTIVE_SET = active_r;
  assign RAMPING    = (state_r == RAMP_S);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [GW-1:0] from_pos;
  assign from_pos = active_r ? set2_r[G_POS] : set1_r[G_POS];
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_manual_select: assert property (!auto_mode |=> active_r == $past(GAIN_SEL)) // R1
    else $error("manual select not followed");
  // a mode or control change lands one edge before the sequencer can fall back to idle
  a_auto_only_pos: assert property (state_r != IDLE_S |-> $past(auto_run)) // R2
    else $error("auto sequence outside position control");
  a_wait_start: assert property (state_r == IDLE_S && auto_run && desired != active_r
    |=> state_r == WAIT_S && target_r == $past(desired)) // R3
    else $error("wait not started on condition change");
  a_ramp_end: assert property (state_r == RAMP_S && cur_ramp_done && auto_run
    |=> state_r == IDLE_S && active_r == $past(target_r)) // R4
    else $error("ramp did not finish on target set");
  a_cond_done: assert property (csel == COND_DONE_OFF |-> cond_a == !POSITIONING_DONE_FLAG) // R5
    else $error("condition A source wrong");
  a_fixed_set: assert property (auto_mode && !POSITION_CONTROL
    |=> active_r == $past(csel[0]) && state_r == IDLE_S) // R6
    else $error("fixed set wrong outside position control");
  a_speed_range: assert property (set1_r[G_SPEED] >= 16'h000A && set1_r[G_SPEED] <= 16'h4E20
    && set2_r[G_SPEED] >= 16'h000A && set2_r[G_SPEED] <= 16'h4E20) // R8
    else $error("speed gain out of range");
  a_integ_range: assert property (wr_en && PADDR == 8'h44
    |=> set1_r[G_INTEG] >= 16'h000F && set1_r[G_INTEG] <= 16'hC800) // R9
    else $error("integral time out of range");
  a_force_store: assert property (wr_en && PADDR == 8'h4C
    |=> set1_r[G_FORCE] == $past(PWDATA[15:0])) // R10
    else $error("force filter value not stored");
  a_model_hold: assert property ($changed(model_sel_r)
    |-> $past(!auto_mode && !CMD_BUSY && MOTOR_STOPPED)) // R11
    else $error("model gains switched when not allowed");
  a_wait_time: assert property (state_r == RAMP_S && $past(state_r) == WAIT_S
    |-> $past(cur_wait_done)) // R13
    else $error("ramp began before waiting time");
  a_revert_drop: assert property (state_r == WAIT_S && auto_run && desired == active_r
    |=> state_r == IDLE_S) // R14
    else $error("pending switch not abandoned");
  a_param_live: assert property (state_r == IDLE_S && $past(state_r) == IDLE_S
    && $stable(active_r) |-> EFF_GAIN[G_POS] == $past(from_pos)) // R15
    else $error("effective gain stale");
  c_auto_to_two: cover property (state_r == RAMP_S && target_r ##1 state_r == IDLE_S);
  c_revert:      cover property (state_r == WAIT_S ##1 state_r == IDLE_S && !RAMPING);
  c_manual_flip: cover property (!auto_mode && $rose(active_r));
  c_long_ramp:   cover property (state_r == RAMP_S && ramp_cnt_r == 16'h2);

endmodule : gain_switch
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// host motion controller: option field gain select
// ----------------------------------------------------------------
module host_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // command frames from the bench
  input  wire logic frame_valid,
  input  wire logic frame_sel,
  // option field bit toward the drive
  output logic      gain_sel
);
  // the bit is a level: it holds between frames, like a real option field
  always_ff @(posedge clock) begin
    if (rst) begin
      gain_sel <= 1'b0;
    end else if (frame_valid) begin
      gain_sel <= frame_sel;
    end
  end
endmodule : host_model
`default_nettype wire

// file: sim/gain_switch_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module gain_switch_bench;
  import gain_switch_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int MS = 4; // short ms tick keeps the timed cases brief
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        fv = 1'b0;
  logic        fs = 1'b0;
  logic        pos_ctl = 1'b0;
  logic        cmd_busy = 1'b0;
  logic        stopped = 1'b0;
  logic [3:0]  flags = 4'h0; // ref input, ref idle, near, done
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        gain_sel;
  wire logic        act;
  wire logic        ramping;
  wire logic [NUM_GAINS-1:0][GW-1:0] eff;
  int          err_count = 0;
  int          compares = 0;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  ca [7] = '{8'h40, 8'h44, 8'h44, 8'h4C, 8'h60, 8'h60, 8'h48};
  logic [15:0] cw [7] = '{16'h0005, 16'h0001, 16'hFFFF, 16'hFFFF, 16'h5000, 16'h07D0, 16'h0190};
  logic [15:0] ce [7] = '{16'h000A, 16'h000F, 16'hC800, 16'hFFFF, 16'h4E20, 16'h07D0, 16'h0190};
  logic [3:0]  tv [6] = '{4'h1, 4'h0, 4'h2, 4'h0, 4'h4, 4'h8};
  logic [3:0]  fl [6] = '{4'h0, 4'h1, 4'h0, 4'h2, 4'h0, 4'h0};

  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  gain_switch #(.MS_CYCLES(MS)) dut_u (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .GAIN_SEL(gain_sel), .POSITION_CONTROL(pos_ctl), .POSITIONING_DONE_FLAG(flags[0]),
    .NEAR_POSITION_FLAG(flags[1]), .REF_FILTER_IDLE(flags[2]), .REF_INPUT_PRESENT(flags[3]),
    .CMD_BUSY(cmd_busy), .MOTOR_STOPPED(stopped), .EFF_GAIN(eff), .ACTIVE_SET(act),
    .RAMPING(ramping));

  host_model host_u (
    .clock(clock), .rst(rst), .frame_valid(fv), .frame_sel(fs), .gain_sel(gain_sel));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task complete_run;
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      err_count++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait for the active set; a hang ends the run
  task wait_act(input logic v, output int n);
    n = 0;
    while (act !== v && n < 40) begin
      @(posedge clock);
      n++;
    end
    if (act !== v) begin
      err_count++;
      complete_run();
    end
  endtask : wait_act

  task host_sel(input logic v);
    @(posedge clock);
    fv <= 1'b1;
    fs <= v;
    @(posedge clock);
    fv <= 1'b0;
  endtask : host_sel

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task sc_reset;
    `CHK(eff, {16'h0064, 16'h03E8, 16'h01F4, 16'h0064, 16'h0190, 16'h07D0, 16'h0190})
    `CHK(act, 1'b0)
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK({er, rd}, 33'h0)
    end
    apb(1'b0, 8'h30, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, ADDR_STATUS, 32'h1F);
    `CHK(er, 1'b1)
  endtask : sc_reset

  task sc_clamp;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ca[i], {16'h0, cw[i]});
      apb(1'b0, ca[i], 32'h0);
      `CHK(rd, {16'h0, ce[i]})
    end
    repeat (3) @(posedge clock);
    `CHK(eff[G_SPEED], 16'h000A)
  endtask : sc_clamp

  // fixed set outside position control, then both switch directions with zero times
  task sc_cond;
    int n;
    for (int c = 0; c < 6; c++) begin
      pos_ctl <= 1'b0;
      flags <= fl[c];
      apb(1'b1, ADDR_CONFIG, {24'h0, 4'(c), MODE_AUTO});
      wait_act(c[0], n);
      `CHK(act, c[0])
      pos_ctl <= 1'b1;
      wait_act(1'b0, n);
      `CHK(act, 1'b0)
      flags <= tv[c];
      wait_act(1'b1, n);
      `CHK(act, 1'b1)
      flags <= fl[c];
      wait_act(1'b0, n);
      `CHK(act, 1'b0)
    end
    apb(1'b1, ADDR_CONFIG, 32'h0);
    flags <= 4'h1;
    repeat (12) @(posedge clock);
    `CHK(act, 1'b0)
  endtask : sc_cond

  task sc_timed;
    int   n;
    logic mid;
    flags <= 4'h0;
    apb(1'b1, 8'h68, 32'h0320);
    apb(1'b1, ADDR_WAIT_1, 32'h2);
    apb(1'b1, ADDR_SWT_1, 32'h2);
    apb(1'b1, ADDR_CONFIG, {24'h0, COND_DONE_ON, MODE_AUTO});
    flags <= 4'h1;
    n = 0;
    while (ramping !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    `CHK(n >= MS && n <= 3 * MS, 1'b1)
    if (n >= 40) complete_run();
    mid = 1'b0;
    n = 0;
    while (act !== 1'b1 && n < 40) begin
      @(posedge clock);
      if (eff[G_POS] === 16'h0258) mid = 1'b1;
      n++;
    end
    `CHK(mid, 1'b1)
    `CHK(n >= MS && n <= 3 * MS + 4, 1'b1)
    if (n >= 40) complete_run();
    repeat (2) @(posedge clock);
    `CHK(eff[G_POS], 16'h0320)
  endtask : sc_timed

  // condition drops and returns inside the wait: no switch may follow
  task sc_revert;
    int n;
    apb(1'b1, ADDR_WAIT_2, 32'h3);
    flags <= 4'h0;
    // status read lands inside the wait: waiting bit and set 2 still active
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h00000011)
    flags <= 4'h1;
    n = 0;
    repeat (6 * MS) begin
      @(posedge clock);
      if (act !== 1'b1 || ramping !== 1'b0) n++;
    end
    `CHK(n, 0)
  endtask : sc_revert

  task sc_model;
    int n;
    apb(1'b1, ADDR_CONFIG, 32'h0);
    apb(1'b1, 8'h70, 32'h03E8);
    cmd_busy <= 1'b1;
    stopped <= 1'b1;
    host_sel(1'b1);
    wait_act(1'b1, n);
    repeat (2) @(posedge clock);
    `CHK(eff[G_SPEED], 16'h07D0)
    `CHK(eff[G_MODEL], 16'h01F4)
    cmd_busy <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(eff[G_MODEL], 16'h03E8)
    host_sel(1'b0);
    wait_act(1'b0, n);
    repeat (2) @(posedge clock);
    `CHK(eff[G_SPEED], 16'h000A)
  endtask : sc_model

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    sc_reset();
    sc_clamp();
    sc_cond();
    sc_timed();
    sc_revert();
    sc_model();
    complete_run();
  end
endmodule : gain_switch_bench
`default_nettype wire
